// File: design/adcif_pkg.sv
// Purpose: shared constants and types of the converter host bus interface
// Assumes: 125 MHz system clock, 10-bit offset-binary result
// Notes:   offsets, field positions, counts and the result word and busy reset values live here
package adcif_pkg;

    // =====================================================================
    // timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned THRU_HZ      = 200_000;
    // longest conversion period rounds down to whole cycles, at least one
    localparam int unsigned CONV_CYCLES  = (CLK_HZ / THRU_HZ) < 1 ?
                                           1 : (CLK_HZ / THRU_HZ);
    localparam int unsigned HOLD_CYCLES  = 1;

    // =====================================================================
    // result word layout
    localparam int unsigned RES_W        = 10;
    localparam int unsigned WORD_W       = RES_W + 1;
    localparam int unsigned FLAG_BIT     = 10;
    localparam int unsigned LO_MSB       = 7;
    localparam int unsigned HI_LSB       = 8;
    localparam int unsigned RAW_W        = 12;
    localparam int unsigned CODE_HALF    = 512;
    localparam int unsigned CODE_MAX     = 1023;
    localparam int unsigned FIFO_DEPTH   = 8;

    // =====================================================================
    // reset values
    localparam logic [WORD_W-1:0] WORD_RST = 11'h000;
    localparam logic              BUSY_RST = 1'h1;

    // =====================================================================
    // sequencer states
    typedef enum logic [0:0] {
        ADCIF_IDLE = 1'b0,
        ADCIF_CONV = 1'b1
    } adcif_state_t;

endpackage

// File: design/adcif_fifo.sv
// Purpose: result buffer between the converter and the output register
// Assumes: single clock, synchronous active-high reset
// Notes:   flip-flop storage; ready on the fill side is the honest not-full
`timescale 1ns/1ps
module adcif_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST = (PTR_W)'(DEPTH - 1);

    initial begin
        if (DEPTH < 2 || WIDTH < 1)
            $error("adcif_fifo: depth below two or width zero");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    // =====================================================================
    // flags and read data
    assign in_ready_o  = (count != FULL_CNT);
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];

    // storage needs no reset; only pointers and count carry control state
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            if (pop)  rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            if (push & ~pop)      count <= count + 1'b1;
            else if (pop & ~push) count <= count - 1'b1;
        end
    end
endmodule // adcif_fifo

// File: design/adcif_top.sv
// Purpose: control and bus interface of a 10-bit sampling converter
// Assumes: bus strobes synchronous to clk_i; raw_code_i is the digitised
//          input from the comparator array, two's complement
// Notes:   three-state pins split into data and enable; enables registered
//
// Functional notes
// - produce a 10-bit result per conversion
// - sample next input as previous conversion ends
// - write pulse starts one, held converts continuously
// - busy low converting, high when complete
// - busy floats when read and select high
// - hold low marks each conversion start
// - read pulse with select enables data drivers
// - read held low refreshes data each conversion outside slow memory mode
// - wide bus enables all bits and flag
// - narrow bus enables only the selected byte
// - high byte is bits 9,8 and flag
// - bit 9 most significant, high means one
// - flag set when value lies above full scale or below zero
`timescale 1ns/1ps
module adcif_top
    import adcif_pkg::*;
#(
    parameter int unsigned CONV_LEN = CONV_CYCLES,
    parameter int unsigned BUF_DEPTH = FIFO_DEPTH
) (
    input  wire logic                    clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    chip_sel_n_i,
    input  wire logic                    wr_n_i,
    input  wire logic                    rd_n_i,
    input  wire logic                    slow_memory_sel_i,
    input  wire logic                    bus_wide_i,
    input  wire logic                    upper_byte_sel_i,
    input  wire logic signed [RAW_W-1:0] raw_code_i,
    output logic             [RES_W-1:0] result_o,
    output logic                         result_lo_oe_o,
    output logic                         result_hi_oe_o,
    output logic                         range_exceeded_flag_o,
    output logic                         range_oe_o,
    output logic                         busy_o,
    output logic                         busy_oe_o,
    output logic                         hold_n_o
);
    localparam int unsigned CNT_W = $clog2(CONV_LEN + 1);
    // one idle cycle sits between back-to-back conversions
    localparam logic [CNT_W-1:0] CNT_LOAD = (CNT_W)'(CONV_LEN - 2);

    initial begin
        if (CONV_LEN < 3)
            $error("adcif_top: conversion length below three cycles");
        if (BUF_DEPTH < 2)
            $error("adcif_top: buffer depth below two");
    end

    // =====================================================================
    // encoding: offset binary with saturation and out-of-range flag
    function automatic logic [WORD_W-1:0] adcif_encode(
        input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W:0] biased;
        biased = {raw[RAW_W-1], raw} + $signed((RAW_W+1)'(CODE_HALF));
        if (biased < 0)
            adcif_encode = {1'b1, {RES_W{1'b0}}};
        else if (biased > $signed((RAW_W+1)'(CODE_MAX)))
            adcif_encode = {1'b1, {RES_W{1'b1}}};
        else
            adcif_encode = {1'b0, biased[RES_W-1:0]};
    endfunction

    // =====================================================================
    // state
    adcif_state_t       state;
    adcif_state_t       next_state;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]   next_cnt;
    logic signed [RAW_W-1:0] sample;
    logic               wr_n_q;
    logic               start_pend;
    logic [WORD_W-1:0]  out_word;

    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [WORD_W-1:0]  fifo_out_data;

    // =====================================================================
    // strobe decode
    wire sel_act   = ~chip_sel_n_i;
    wire wr_act    = sel_act & ~wr_n_i;
    wire rd_act    = sel_act & ~rd_n_i;
    wire wr_fall   = sel_act & wr_n_q & ~wr_n_i;
    wire conv_end  = (state == ADCIF_CONV) && (cnt == '0);
    wire start_req = start_pend | wr_act;
    // buffer room stalls the sequencer rather than dropping a result
    wire start_go  = (state == ADCIF_IDLE) & start_req & fifo_in_ready;
    // an edge that starts a conversion at once is not kept a second time;
    // an edge landing on a start served from the pending flag is kept
    wire pend_set  = wr_fall & ~(start_go & ~start_pend);
    wire push      = conv_end;
    // read held refreshes
    // slow memory mode freezes the output register during a read
    wire drain_ok  = ~(slow_memory_sel_i & rd_act);
    wire pop       = fifo_out_valid & drain_ok;
    wire [WORD_W-1:0] conv_word = adcif_encode(sample);

    // =====================================================================
    // sequencer next state
    // clock timed
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            ADCIF_IDLE: begin
                if (start_go) begin
                    next_state = ADCIF_CONV;
                    next_cnt   = CNT_LOAD;
                end
            end
            ADCIF_CONV: begin
                if (cnt == '0) next_state = ADCIF_IDLE;
                else           next_cnt   = cnt - 1'b1;
            end
            default: begin
                next_state = ADCIF_IDLE;
                next_cnt   = '0;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state <= ADCIF_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // a short write pulse during a conversion is kept; set wins over clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_n_q     <= 1'b1;
            start_pend <= 1'b0;
        end else begin
            wr_n_q <= wr_n_i;
            if (pend_set)      start_pend <= 1'b1;
            else if (start_go) start_pend <= 1'b0;
        end
    end

    // track then hold
    // the hold edge takes the next input while the last result leaves
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sample   <= '0;
            hold_n_o <= 1'b1;
        end else begin
            if (start_go) sample <= raw_code_i;
            hold_n_o <= ~start_go;
        end
    end

    // =====================================================================
    // result buffer
    adcif_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) i_adcif_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (conv_word),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (drain_ok),
        .out_data_o  (fifo_out_data)
    );

    // latch with busy
    // word and flag load together so a read never mixes two conversions
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            out_word <= WORD_RST;
            busy_o   <= BUSY_RST;
        end else begin
            if (pop) out_word <= fifo_out_data;
            if (start_go)                  busy_o <= 1'b0;
            else if (pop & (state == ADCIF_IDLE) & ~push)
                                           busy_o <= 1'b1;
        end
    end

    assign result_o              = out_word[RES_W-1:0];
    assign range_exceeded_flag_o = out_word[FLAG_BIT];

    // =====================================================================
    // output enables
    wire lo_en = rd_act & (bus_wide_i | ~upper_byte_sel_i);
    wire hi_en = rd_act & (bus_wide_i | upper_byte_sel_i);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            result_lo_oe_o <= 1'b0;
            result_hi_oe_o <= 1'b0;
            range_oe_o     <= 1'b0;
            busy_oe_o      <= 1'b0;
        end else begin
            result_lo_oe_o <= lo_en;
            result_hi_oe_o <= hi_en;
            range_oe_o     <= hi_en;
            busy_oe_o      <= ~(rd_n_i & chip_sel_n_i);
        end
    end

    // =====================================================================
    // checks
    logic [CNT_W-1:0] conv_age;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i)     conv_age <= '0;
        else if (start_go) conv_age <= '0;
        else if (state == ADCIF_CONV) conv_age <= conv_age + 1'b1;
    end

    sequence s_held_end;
        conv_end ##1 (wr_act & fifo_in_ready);
    endsequence

    sequence s_hold_strobe;
        ##[0:1] !hold_n_o;
    endsequence

    AST_HOLD_ON_START: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        start_go |=> !hold_n_o && (state == ADCIF_CONV))
        else $error("hold strobe missing at conversion start");

    AST_BUSY_LOW_CONV: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (state == ADCIF_CONV) |-> !busy_o)
        else $error("busy high while converting");

    AST_CONV_LENGTH: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        conv_end |-> (conv_age == (CNT_W)'(CONV_LEN - 2)))
        else $error("conversion length wrong");

    AST_BUSY_RISE_LOAD: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $rose(busy_o) |-> $past(pop))
        else $error("busy rose without a result load");

    AST_RESULT_LOAD: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        pop |=> (result_o == $past(fifo_out_data[RES_W-1:0]))
                && (range_exceeded_flag_o == $past(fifo_out_data[FLAG_BIT])))
        else $error("result register did not take buffer word");

    AST_NARROW_OE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (rd_act && !bus_wide_i) |=>
            (result_lo_oe_o != result_hi_oe_o)
            && (result_hi_oe_o == $past(upper_byte_sel_i))
            && (range_oe_o == result_hi_oe_o))
        else $error("narrow bus enabled wrong byte");

    AST_WIDE_OE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (rd_act && bus_wide_i) |=>
            result_lo_oe_o && result_hi_oe_o && range_oe_o)
        else $error("wide bus left a driver off");

    AST_IDLE_FLOAT: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (chip_sel_n_i && rd_n_i) |=>
            !busy_oe_o && !result_lo_oe_o && !result_hi_oe_o)
        else $error("driver on while unselected");

    AST_RANGE_CODE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (push && conv_word[FLAG_BIT]) |->
            (conv_word[RES_W-1:0] == '0) || (&conv_word[RES_W-1:0]))
        else $error("out of range code not saturated");

    AST_HELD_RESTART: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        s_held_end |-> s_hold_strobe)
        else $error("held write did not restart conversion");

    AST_SLOW_FREEZE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (slow_memory_sel_i && rd_act) |=> $stable(result_o))
        else $error("result changed during slow memory read");

    AST_HOLD_PULSE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        !hold_n_o |=> hold_n_o)
        else $error("hold strobe longer than one cycle");

    AST_SEL_BUSY_OE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (!chip_sel_n_i || !rd_n_i) |=> busy_oe_o)
        else $error("busy driver off while selected");

    // a start taken straight from the strobe must not also queue one
    AST_PEND_NO_DOUBLE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        (start_go && !start_pend) |=> !start_pend)
        else $error("starting edge queued a second conversion");

endmodule // adcif_top

// File: tb/adcif_host.sv
// Purpose: host model driving the converter bus strobes and input code
// Assumes: bus lines change only after a falling edge of clk_i
// Notes:   raw code may step on every hold pulse to tag each sample
`timescale 1ns/1ps
module adcif_host
    import adcif_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    hold_n_i,
    output logic                         chip_sel_n_o,
    output logic                         wr_n_o,
    output logic                         rd_n_o,
    output logic                         wide_o,
    output logic                         upper_o,
    output logic                         slow_o,
    output logic signed [RAW_W-1:0]      raw_code_o
);
    logic step;

    // ==================================================================
    // idle bus at time zero: nothing selected
    initial begin
        chip_sel_n_o = 1'b1;
        wr_n_o       = 1'b1;
        rd_n_o       = 1'b1;
        wide_o       = 1'b0;
        upper_o      = 1'b0;
        slow_o       = 1'b0;
        raw_code_o   = 12'sh000;
        step         = 1'b0;
    end

    // one bus setting, held until the next call
    task automatic drive(input logic cs, wr, rd, wide, up, slow);
        @(negedge clk_i);
        chip_sel_n_o = cs;
        wr_n_o       = wr;
        rd_n_o       = rd;
        wide_o       = wide;
        upper_o      = up;
        slow_o       = slow;
    endtask

    task automatic set_raw(input logic signed [RAW_W-1:0] v, input logic s);
        @(negedge clk_i);
        raw_code_o = v;
        step       = s;
    endtask

    // a new value per sample makes lost or reordered words visible
    always @(negedge clk_i) begin
        if (step && hold_n_i === 1'b0) begin
            raw_code_o <= raw_code_o + 12'sh004;
        end
    end
endmodule // adcif_host

// File: tb/adcif_top_test.sv
// Purpose: self-checking bench of the converter host bus interface
// Assumes: conversion length shortened to 8 cycles
// Notes:   expected words are worked out from offset binary rules
`timescale 1ns/1ps
module adcif_top_test;
    import adcif_pkg::*;
    localparam int unsigned CL = 8;
    logic                    clk_i = 1'b0;
    logic                    sys_rst_i = 1'b1;
    logic                    cs_n, wr_n, rd_n, wide, up, slow;
    logic signed [RAW_W-1:0] raw;
    logic        [RES_W-1:0] result;
    logic                    lo_oe, hi_oe, flag, r_oe, busy, b_oe, hold_n;
    int                      err_count = 0;
    int                      n_checks = 0;

    always #4 clk_i = ~clk_i;

    adcif_host i_adcif_host (.clk_i(clk_i), .hold_n_i(hold_n),
        .chip_sel_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .wide_o(wide),
        .upper_o(up), .slow_o(slow), .raw_code_o(raw));

    adcif_top #(.CONV_LEN(CL), .BUF_DEPTH(FIFO_DEPTH)) i_adcif_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .chip_sel_n_i(cs_n),
        .wr_n_i(wr_n), .rd_n_i(rd_n), .slow_memory_sel_i(slow),
        .bus_wide_i(wide), .upper_byte_sel_i(up), .raw_code_i(raw),
        .result_o(result), .result_lo_oe_o(lo_oe), .result_hi_oe_o(hi_oe),
        .range_exceeded_flag_o(flag), .range_oe_o(r_oe), .busy_o(busy),
        .busy_oe_o(b_oe), .hold_n_o(hold_n));

    // ==================================================================
    // comparison and closing
    task automatic chk(input string n, input logic [10:0] e, g);
        n_checks++;
        if (e !== g) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // bounded wait for conversion complete
    task automatic wait_busy();
        for (int i = 0; i < 64 && busy !== 1'b1; i++) @(negedge clk_i);
        chk("busy_o", 11'h001, {10'h000, busy});
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset();
        chk("busy_rst", 11'h001, {10'h000, busy});
        chk("hold_rst", 11'h001, {10'h000, hold_n});
        chk("oe_rst", 11'h000, {7'h00, lo_oe, hi_oe, r_oe, b_oe});
        chk("res_rst", 11'h000, {flag, result});
    endtask

    task automatic t_conv(input logic signed [RAW_W-1:0] v,
                          input logic [10:0] e);
        i_adcif_host.set_raw(v, 1'b0);
        i_adcif_host.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        i_adcif_host.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("hold_n_o", 11'h000, {10'h000, hold_n});
        chk("busy_o", 11'h000, {10'h000, busy});
        wait_busy();
        i_adcif_host.drive(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        @(negedge clk_i);
        chk("word", e, {flag, result});
        chk("wide_oe", 11'h007, {8'h00, lo_oe, hi_oe, r_oe});
        i_adcif_host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        @(negedge clk_i);
        chk("rel_oe", 11'h000, {7'h00, lo_oe, hi_oe, r_oe, b_oe});
    endtask

    task automatic t_bytes();
        for (int u = 0; u < 2; u++) begin
            i_adcif_host.drive(1'b0, 1'b1, 1'b0, 1'b0, u[0], 1'b0);
            @(negedge clk_i);
            // one byte enabled
            chk("byte_oe", {7'h00, ~u[0], u[0], u[0], 1'b1},
                {7'h00, lo_oe, hi_oe, r_oe, b_oe});
        end
        i_adcif_host.drive(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        @(negedge clk_i);
        chk("busy_oe", 11'h001, {10'h000, b_oe});
    endtask

    // pulse during a conversion is remembered, held strobe repeats
    task automatic t_held();
        int gap;
        logic [9:0] first;
        i_adcif_host.set_raw(12'sh010, 1'b1);
        i_adcif_host.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        while (hold_n !== 1'b0) @(negedge clk_i);
        @(negedge clk_i);
        gap = 1;
        while (hold_n !== 1'b0 && gap < 64) begin
            @(negedge clk_i);
            gap++;
        end
        chk("start_gap", 11'(CL), gap[10:0]);
        first = result;
        repeat (2 * CL) @(negedge clk_i);
        chk("refresh", 11'h001, {10'h000, result !== first});
        chk("held_oe", 11'h001, {10'h000, lo_oe});
        i_adcif_host.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        i_adcif_host.drive(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (3) @(negedge clk_i);
        i_adcif_host.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        i_adcif_host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        gap = 0;
        repeat (4 * CL) begin
            @(negedge clk_i);
            gap += (hold_n === 1'b0);
        end
        // the one remembered pulse starts exactly one conversion
        chk("queued", 11'h001, gap[10:0]);
    endtask

    // slow mode read freezes output, buffer fills then drains
    task automatic t_fifo();
        int n;
        logic [10:0] kept;
        i_adcif_host.set_raw(12'sh000, 1'b1);
        kept = {flag, result};
        i_adcif_host.drive(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        n = 0;
        repeat (200) begin
            @(negedge clk_i);
            n += (hold_n === 1'b0);
        end
        chk("fill_cnt", 11'(FIFO_DEPTH), n[10:0]);
        chk("frozen", kept, {flag, result});
        i_adcif_host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (4 * FIFO_DEPTH) @(negedge clk_i);
        chk("drained", 11'h200 + 11'((n - 1) * 4), {flag, result});
        chk("busy_end", 11'h001, {10'h000, busy});
    endtask

    // reset in mid conversion returns to idle with nothing left pending
    task automatic t_midrst();
        i_adcif_host.drive(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        i_adcif_host.drive(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        chk("busy_pre", 11'h000, {10'h000, busy});
        sys_rst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        t_reset();
        repeat (2 * CL) @(negedge clk_i);
        chk("no_restart", 11'h001, {10'h000, busy});
        chk("hold_idle", 11'h001, {10'h000, hold_n});
    endtask

    // ==================================================================
    // main sequence and watchdog
    initial begin
        repeat (16) @(negedge clk_i);
        sys_rst_i = 1'b0;
        @(negedge clk_i);
        t_reset();
        t_conv(12'sh064, 11'h264);
        t_conv(12'sh1ff, 11'h3ff);
        t_conv(12'sh258, 11'h7ff);
        t_conv(-12'sh200, 11'h000);
        t_conv(-12'sh258, 11'h400);
        t_bytes();
        t_held();
        t_fifo();
        t_midrst();
        finish_test();
    end

    initial begin
        #200_000;
        err_count++;
        finish_test();
    end
endmodule // adcif_top_test
